// *** ppc_defs.svh ***
// constants of the protected-mode privilege checker
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

// ****************************************
// exception vectors
// ****************************************
`define PPC_VEC_DF 8'h08
`define PPC_VEC_CSO 8'h09
`define PPC_VEC_TSB 8'h0a
`define PPC_VEC_NP 8'h0b
`define PPC_VEC_SS 8'h0c
`define PPC_VEC_GP 8'h0d

// ****************************************
// descriptor and flag layout
// ****************************************
`define PPC_TSB_MIN_LIMIT 16'h002b
`define PPC_TYPE_TSB_AVAIL 4'h1
`define PPC_TYPE_TSB_BUSY 4'h3
`define PPC_IO_PRIVILEGE_FIELD_HI 14
`define PPC_IO_PRIVILEGE_FIELD_LO 13
`define PPC_NEST_BIT 14
`define PPC_IE_BIT 9
`define PPC_FLAGS_RST 16'h0000
`define PPC_LEVEL_RST 2'h0
`define PPC_RING0 2'h0
`define PPC_RPL_MASK 16'hfffc
`define PPC_NO_ERR 16'h0000

`endif

// *** ppc_pkg.sv ***
// types of the protected-mode privilege checker
`default_nettype none
package ppc_pkg;
  typedef enum logic [3:0] {
    PPC_OP_SEG_LOAD = 4'h0,
    PPC_OP_OPERAND = 4'h1,
    PPC_OP_PRIV = 4'h2,
    PPC_OP_JMP = 4'h3,
    PPC_OP_CALL = 4'h4,
    PPC_OP_RET = 4'h5,
    PPC_OP_INT_RETURN = 4'h6,
    PPC_OP_FLAG_POP = 4'h7,
    PPC_OP_INT = 4'h8,
    PPC_OP_LOAD_TASK_SEL = 4'h9
  } ppc_op_t;

  typedef enum logic [1:0] {
    SEG_ES = 2'h0,
    SEG_CS = 2'h1,
    SEG_SS = 2'h2,
    SEG_DS = 2'h3
  } ppc_seg_t;

  typedef enum logic [2:0] {
    DC_DATA_RO = 3'h0,
    DC_DATA_RW = 3'h1,
    DC_CODE_XO = 3'h2,
    DC_CODE_RX = 3'h3,
    DC_TASK_BLOCK = 3'h4,
    DC_TASK_GATE = 3'h5,
    DC_CALL_GATE = 3'h6,
    DC_SYS_OTHER = 3'h7
  } ppc_dclass_t;

  typedef enum logic [3:0] {
    PI_LOAD_INTERRUPT_TABLE_BASE = 4'h0,
    PI_LOAD_GLOBAL_TABLE_BASE = 4'h1,
    PI_LOAD_LOCAL_TABLE_SELECTOR = 4'h2,
    PI_LOAD_TASK_SELECTOR = 4'h3,
    PI_LOAD_MACHINE_STATUS_WORD = 4'h4,
    PI_CLEAR_TASK_SWITCHED = 4'h5,
    PI_HALT_INSTRUCTION = 4'h6,
    PI_PORT_IN = 4'h7,
    PI_PORT_OUT = 4'h8,
    PI_STRING_IN = 4'h9,
    PI_STRING_OUT = 4'ha,
    PI_SET_INTERRUPT_ENABLE = 4'hb,
    PI_CLEAR_INTERRUPT_ENABLE = 4'hc,
    PI_LOCK_PREFIX = 4'hd,
    PI_NONE = 4'hf
  } ppc_pinstr_t;
endpackage
`default_nettype wire

// *** ppc_flag_filter.sv ***
// flag merge for interrupt_return and flag_pop
`include "ppc_defs.svh"
`default_nettype none
module ppc_flag_filter #(
  parameter int FLAG_W = 16
) (
  input wire logic [FLAG_W-1:0] cur_flags_i,
  input wire logic [FLAG_W-1:0] new_flags_i,
  input wire logic [1:0] level_i,
  output logic [FLAG_W-1:0] merged_o
);
  if (FLAG_W <= `PPC_IO_PRIVILEGE_FIELD_HI) begin : g_chk
    $error("ppc_flag_filter: flag word too narrow");
  end

  logic [1:0] io_field;
  logic keep_ie;
  logic keep_io;
  logic [FLAG_W-1:0] keep_mask;

  assign io_field = cur_flags_i[`PPC_IO_PRIVILEGE_FIELD_HI:`PPC_IO_PRIVILEGE_FIELD_LO];
  // silent masking: no fault is raised, the old bits are simply kept
  assign keep_ie = level_i > io_field;
  assign keep_io = level_i != `PPC_RING0;

  always_comb begin
    keep_mask = '0;
    keep_mask[`PPC_IE_BIT] = keep_ie;
    keep_mask[`PPC_IO_PRIVILEGE_FIELD_HI] = keep_io;
    keep_mask[`PPC_IO_PRIVILEGE_FIELD_LO] = keep_io;
    merged_o = (cur_flags_i & keep_mask) | (new_flags_i & ~keep_mask);
  end
endmodule
`default_nettype wire

// *** ppc_checker.sv ***
// protection checks, stack switching and task switch control of the processor
`include "ppc_defs.svh"
`default_nettype none
module ppc_checker
  import ppc_pkg::*;
#(
  parameter int BASE_W = 24,
  parameter int FLAG_W = 16
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire ppc_op_t req_op_i,
  input wire ppc_seg_t req_seg_i,
  input wire logic [15:0] req_selector_i,
  input wire logic [15:0] table_limit_i,
  input wire logic desc_present_i,
  input wire ppc_dclass_t desc_class_i,
  input wire logic [3:0] desc_type_i,
  input wire logic [15:0] desc_limit_i,
  input wire logic [BASE_W-1:0] desc_base_i,
  input wire logic priv_fail_i,
  input wire logic [1:0] target_level_i,
  input wire logic call_gate_i,
  input wire logic [4:0] gate_words_i,
  input wire logic [2:0][15:0] tsb_stack_sel_i,
  input wire logic [2:0][15:0] tsb_stack_ptr_i,
  input wire logic [15:0] cur_ss_i,
  input wire logic [15:0] cur_sp_i,
  input wire logic [15:0] popped_ss_i,
  input wire logic [15:0] popped_sp_i,
  input wire logic [15:0] ret_adjust_i,
  input wire logic access_write_i,
  input wire logic [15:0] op_base_i,
  input wire logic [15:0] op_disp_i,
  input wire logic [15:0] seg_limit_i,
  input wire ppc_pinstr_t pinstr_i,
  input wire logic [FLAG_W-1:0] new_flags_i,
  input wire logic [7:0] exc_vector_i,
  input wire logic exc_is_fault_i,
  input wire logic [15:0] exc_err_sel_i,
  input wire logic [15:0] instr_start_ip_i,
  input wire logic [15:0] next_ip_i,
  output logic done_o,
  output logic fault_o,
  output logic [7:0] fault_vec_o,
  output logic err_push_o,
  output logic [15:0] err_code_o,
  output logic restartable_o,
  output logic [15:0] ret_ip_o,
  output logic stack_load_o,
  output logic [15:0] stack_sel_o,
  output logic [15:0] stack_ptr_o,
  output logic push_old_stack_o,
  output logic [15:0] old_ss_o,
  output logic [15:0] old_sp_o,
  output logic [4:0] copy_words_o,
  output logic task_switch_o,
  output logic mark_busy_o,
  output logic [3:0] busy_type_o,
  output logic [15:0] task_selector_register_o,
  output logic [BASE_W-1:0] task_base_o,
  output logic [15:0] task_limit_o,
  output logic [FLAG_W-1:0] flags_o,
  output logic [1:0] current_privilege_level_o
);
  if (BASE_W < 16 || FLAG_W <= `PPC_IO_PRIVILEGE_FIELD_HI) begin : g_chk
    $error("ppc_checker: unsupported width");
  end

  // ****************************************
  // vector properties
  // ****************************************
  function automatic logic vec_pushes(input logic [7:0] v);
    vec_pushes = v == `PPC_VEC_DF || v == `PPC_VEC_TSB || v == `PPC_VEC_NP ||
                 v == `PPC_VEC_SS || v == `PPC_VEC_GP;
  endfunction

  function automatic logic vec_restarts(input logic [7:0] v);
    // double fault, overrun and protection faults are reported but not restartable
    vec_restarts = v == `PPC_VEC_TSB || v == `PPC_VEC_NP || v == `PPC_VEC_SS;
  endfunction

  // ****************************************
  // decode
  // ****************************************
  logic [1:0] level;
  logic [1:0] io_field;
  logic nested;
  logic is_code;
  logic is_sys;
  logic to_ss;
  assign level = current_privilege_level_o;
  assign io_field = flags_o[`PPC_IO_PRIVILEGE_FIELD_HI:`PPC_IO_PRIVILEGE_FIELD_LO];
  assign nested = flags_o[`PPC_NEST_BIT];
  assign is_code = desc_class_i == DC_CODE_XO || desc_class_i == DC_CODE_RX;
  assign is_sys = desc_class_i inside {DC_TASK_BLOCK, DC_TASK_GATE, DC_CALL_GATE, DC_SYS_OTHER};
  assign to_ss = req_seg_i == SEG_SS;

  // ****************************************
  // segment register load checks
  // ****************************************
  logic tbl_over;
  logic sl_type_bad;
  logic sl_fault;
  logic [7:0] sl_vec;
  assign tbl_over = {req_selector_i[15:3], 3'h7} > table_limit_i;
  assign sl_type_bad = (to_ss && (desc_class_i == DC_DATA_RO || desc_class_i == DC_CODE_RX)) ||
                       (req_seg_i != SEG_CS && (is_sys || desc_class_i == DC_CODE_XO)) ||
                       (req_seg_i == SEG_CS && (desc_class_i == DC_DATA_RO || desc_class_i == DC_DATA_RW));
  assign sl_fault = tbl_over || !desc_present_i || priv_fail_i || sl_type_bad;
  // checks are ranked in table order: limit, presence, privilege, type
  assign sl_vec = tbl_over ? `PPC_VEC_GP :
                  !desc_present_i ? (to_ss ? `PPC_VEC_SS : `PPC_VEC_NP) :
                  `PPC_VEC_GP;

  // ****************************************
  // operand reference checks
  // ****************************************
  logic [15:0] op_off;
  logic or_type_bad;
  logic or_fault;
  logic [7:0] or_vec;
  // 16-bit sum on purpose: a carry out of the offset wraps and is not a fault
  assign op_off = op_base_i + op_disp_i;
  assign or_type_bad = (access_write_i && (is_code || desc_class_i == DC_DATA_RO)) ||
                       (!access_write_i && desc_class_i == DC_CODE_XO);
  assign or_fault = or_type_bad || op_off > seg_limit_i;
  assign or_vec = (!or_type_bad && to_ss) ? `PPC_VEC_SS : `PPC_VEC_GP;

  // ****************************************
  // privileged instruction checks
  // ****************************************
  logic ring0_only;
  logic io_only;
  logic pi_fault;
  assign ring0_only = pinstr_i inside {PI_LOAD_INTERRUPT_TABLE_BASE, PI_LOAD_GLOBAL_TABLE_BASE,
                      PI_LOAD_LOCAL_TABLE_SELECTOR, PI_LOAD_TASK_SELECTOR, PI_LOAD_MACHINE_STATUS_WORD,
                      PI_CLEAR_TASK_SWITCHED, PI_HALT_INSTRUCTION};
  assign io_only = pinstr_i inside {PI_PORT_IN, PI_PORT_OUT, PI_STRING_IN, PI_STRING_OUT,
                   PI_SET_INTERRUPT_ENABLE, PI_CLEAR_INTERRUPT_ENABLE, PI_LOCK_PREFIX};
  assign pi_fault = (ring0_only && level != `PPC_RING0) ||
                    (io_only && level > io_field);

  // ****************************************
  // task switch and privilege transfer
  // ****************************************
  logic jmp_call;
  logic ts_req;
  logic ltr_req;
  logic tb_busy;
  logic tb_short;
  logic ts_fault;
  logic [7:0] ts_vec;
  logic jc_code;
  logic int_gate;
  logic xfer_in;
  logic ret_like;
  logic ret_out;
  assign jmp_call = req_op_i == PPC_OP_JMP || req_op_i == PPC_OP_CALL;
  assign ts_req = (jmp_call && (desc_class_i == DC_TASK_BLOCK || desc_class_i == DC_TASK_GATE)) ||
                  (req_op_i == PPC_OP_INT && desc_class_i == DC_TASK_GATE) ||
                  (req_op_i == PPC_OP_INT_RETURN && nested);
  assign ltr_req = req_op_i == PPC_OP_LOAD_TASK_SEL;
  // returning to the previous task finds it busy by design, so only new entries check
  assign tb_busy = desc_type_i == `PPC_TYPE_TSB_BUSY && req_op_i != PPC_OP_INT_RETURN;
  assign tb_short = desc_limit_i <= `PPC_TSB_MIN_LIMIT;
  assign ts_fault = tb_busy || tb_short || (ltr_req && level != `PPC_RING0);
  assign ts_vec = tb_short && !tb_busy && !(ltr_req && level != `PPC_RING0) ? `PPC_VEC_TSB : `PPC_VEC_GP;
  assign jc_code = jmp_call && !ts_req;
  assign int_gate = req_op_i == PPC_OP_INT && desc_class_i != DC_TASK_GATE;
  assign xfer_in = (jc_code || int_gate) && target_level_i < level;
  assign ret_like = req_op_i == PPC_OP_RET || (req_op_i == PPC_OP_INT_RETURN && !nested);
  assign ret_out = ret_like && req_selector_i[1:0] != level;

  // ****************************************
  // fault selection and delivery properties
  // ****************************************
  logic next_fault;
  logic [7:0] next_vec;
  logic [15:0] next_err;
  logic [7:0] prop_vec;
  logic prop_on;
  logic [FLAG_W-1:0] merged_flags;
  always_comb begin
    next_fault = 1'b0;
    next_vec = `PPC_VEC_GP;
    next_err = `PPC_NO_ERR;
    case (req_op_i)
      PPC_OP_SEG_LOAD: begin
        next_fault = sl_fault;
        next_vec = sl_vec;
        next_err = req_selector_i & `PPC_RPL_MASK;
      end
      PPC_OP_OPERAND: begin
        next_fault = or_fault;
        next_vec = or_vec;
      end
      PPC_OP_PRIV: begin
        next_fault = pi_fault;
      end
      PPC_OP_JMP, PPC_OP_CALL, PPC_OP_INT, PPC_OP_INT_RETURN, PPC_OP_LOAD_TASK_SEL: begin
        next_fault = (ts_req || ltr_req) && ts_fault;
        next_vec = ts_vec;
        next_err = req_selector_i & `PPC_RPL_MASK;
      end
      default: begin
        next_fault = 1'b0;
      end
    endcase
  end
  assign prop_vec = next_fault ? next_vec : exc_vector_i;
  assign prop_on = next_fault || (req_op_i == PPC_OP_INT && exc_is_fault_i);

  ppc_flag_filter #(
    .FLAG_W(FLAG_W)
  ) u_flag_filter (
    .cur_flags_i(flags_o),
    .new_flags_i(new_flags_i),
    .level_i(level),
    .merged_o(merged_flags)
  );

  logic take;
  logic act;
  assign take = ce_i && req_valid_i;
  assign act = take && !next_fault;

  // ****************************************
  // result registers
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
      fault_o <= 1'b0;
      fault_vec_o <= `PPC_VEC_GP;
      err_push_o <= 1'b0;
      err_code_o <= `PPC_NO_ERR;
      restartable_o <= 1'b0;
      ret_ip_o <= 16'h0000;
    end else if (ce_i) begin
      done_o <= req_valid_i;
      fault_o <= req_valid_i && next_fault;
      if (req_valid_i) begin
        fault_vec_o <= prop_vec;
        err_push_o <= prop_on && vec_pushes(prop_vec);
        err_code_o <= next_fault ? next_err : exc_err_sel_i & `PPC_RPL_MASK;
        restartable_o <= prop_on && vec_restarts(prop_vec);
        // the overrun is found after the escape op has moved on
        ret_ip_o <= prop_vec == `PPC_VEC_CSO ? next_ip_i : instr_start_ip_i;
      end
    end
  end

  // ****************************************
  // stack switching
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      stack_load_o <= 1'b0;
      push_old_stack_o <= 1'b0;
      stack_sel_o <= 16'h0000;
      stack_ptr_o <= 16'h0000;
      old_ss_o <= 16'h0000;
      old_sp_o <= 16'h0000;
      copy_words_o <= 5'h00;
    end else if (ce_i) begin
      stack_load_o <= act && (xfer_in || ret_out);
      push_old_stack_o <= act && xfer_in;
      if (act && xfer_in) begin
        stack_sel_o <= tsb_stack_sel_i[target_level_i];
        stack_ptr_o <= tsb_stack_ptr_i[target_level_i];
        old_ss_o <= cur_ss_i;
        old_sp_o <= cur_sp_i;
        copy_words_o <= (req_op_i == PPC_OP_CALL && call_gate_i) ? gate_words_i : 5'h00;
      end else if (act && ret_out) begin
        stack_sel_o <= popped_ss_i;
        stack_ptr_o <= popped_sp_i + ret_adjust_i;
        copy_words_o <= 5'h00;
      end
    end
  end

  // ****************************************
  // task register, flags and level
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      task_switch_o <= 1'b0;
      mark_busy_o <= 1'b0;
      busy_type_o <= `PPC_TYPE_TSB_AVAIL;
      task_selector_register_o <= 16'h0000;
      task_base_o <= '0;
      task_limit_o <= 16'h0000;
    end else if (ce_i) begin
      task_switch_o <= act && ts_req;
      mark_busy_o <= act && (ltr_req || (ts_req && req_op_i != PPC_OP_INT_RETURN));
      if (act && (ts_req || ltr_req)) begin
        busy_type_o <= `PPC_TYPE_TSB_BUSY;
        task_selector_register_o <= req_selector_i;
        task_base_o <= desc_base_i;
        task_limit_o <= desc_limit_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      flags_o <= FLAG_W'(`PPC_FLAGS_RST);
      current_privilege_level_o <= `PPC_LEVEL_RST;
    end else if (act) begin
      if (ts_req) begin
        flags_o <= new_flags_i;
        current_privilege_level_o <= target_level_i;
      end else if ((req_op_i == PPC_OP_INT_RETURN && !nested) || req_op_i == PPC_OP_FLAG_POP) begin
        flags_o <= merged_flags;
      end
      if (ret_like) begin
        current_privilege_level_o <= req_selector_i[1:0];
      end else if (jc_code || int_gate) begin
        current_privilege_level_o <= target_level_i;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_ring0_instr;
    @(posedge clock_i) disable iff (!reset_n_i)
      take && req_op_i == PPC_OP_PRIV && ring0_only && level != `PPC_RING0 |=>
        fault_o && fault_vec_o == `PPC_VEC_GP && err_code_o == `PPC_NO_ERR;
  endproperty
  a_ring0_instr: assert property (p_ring0_instr) else $error("ring 0 instruction not trapped");

  property p_io_instr;
    @(posedge clock_i) disable iff (!reset_n_i)
      take && req_op_i == PPC_OP_PRIV && io_only |=> fault_o == ($past(level) > $past(io_field));
  endproperty
  a_io_instr: assert property (p_io_instr) else $error("io instruction check wrong");

  property p_ss_not_present;
    @(posedge clock_i) disable iff (!reset_n_i)
      take && req_op_i == PPC_OP_SEG_LOAD && to_ss && !tbl_over && !desc_present_i |=>
        fault_vec_o == `PPC_VEC_SS && restartable_o && err_push_o;
  endproperty
  a_ss_not_present: assert property (p_ss_not_present) else $error("stack not-present not 12");

  property p_limit;
    @(posedge clock_i) disable iff (!reset_n_i)
      take && req_op_i == PPC_OP_OPERAND && !or_type_bad && op_off > seg_limit_i |=>
        fault_o && fault_vec_o == ($past(to_ss) ? `PPC_VEC_SS : `PPC_VEC_GP);
  endproperty
  a_limit: assert property (p_limit) else $error("limit fault vector wrong");

  property p_overrun;
    @(posedge clock_i) disable iff (!reset_n_i)
      take && !next_fault && req_op_i == PPC_OP_INT && exc_is_fault_i && exc_vector_i == `PPC_VEC_CSO |=>
        !err_push_o && !restartable_o && ret_ip_o == $past(next_ip_i);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun delivery wrong");

  property p_inward;
    @(posedge clock_i) disable iff (!reset_n_i)
      act && xfer_in |=> stack_load_o && push_old_stack_o && old_sp_o == $past(cur_sp_i) &&
        stack_sel_o == $past(tsb_stack_sel_i[target_level_i]);
  endproperty
  a_inward: assert property (p_inward) else $error("inward stack switch wrong");

  property p_busy;
    @(posedge clock_i) disable iff (!reset_n_i)
      take && jmp_call && ts_req && desc_type_i == `PPC_TYPE_TSB_BUSY |=>
        fault_o && fault_vec_o == `PPC_VEC_GP && !task_switch_o && !mark_busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("busy task block accepted");

  property p_short_block;
    @(posedge clock_i) disable iff (!reset_n_i)
      take && jmp_call && ts_req && !tb_busy && desc_limit_i <= `PPC_TSB_MIN_LIMIT |=>
        fault_vec_o == `PPC_VEC_TSB && !task_switch_o;
  endproperty
  a_short_block: assert property (p_short_block) else $error("short task block accepted");

  property p_io_field_kept;
    @(posedge clock_i) disable iff (!reset_n_i)
      act && req_op_i == PPC_OP_FLAG_POP && level != `PPC_RING0 |=>
        $stable(flags_o[`PPC_IO_PRIVILEGE_FIELD_HI:`PPC_IO_PRIVILEGE_FIELD_LO]) && !fault_o;
  endproperty
  a_io_field_kept: assert property (p_io_field_kept) else $error("io field changed");

  property p_task_load;
    @(posedge clock_i) disable iff (!reset_n_i)
      act && ts_req |=> task_switch_o && task_selector_register_o == $past(req_selector_i) &&
        task_base_o == $past(desc_base_i);
  endproperty
  a_task_load: assert property (p_task_load) else $error("task register not loaded");

  c_task_switch: cover property (@(posedge clock_i) disable iff (!reset_n_i) task_switch_o);
  c_inward: cover property (@(posedge clock_i) disable iff (!reset_n_i) push_old_stack_o && copy_words_o != 5'h00);
  c_outward: cover property (@(posedge clock_i) disable iff (!reset_n_i) stack_load_o && !push_old_stack_o);
  c_stack_fault: cover property (@(posedge clock_i) disable iff (!reset_n_i) fault_o && fault_vec_o == `PPC_VEC_SS);
endmodule
`default_nettype wire

// *** ppc_checker_tb.sv ***
// self-checking bench of the protected-mode privilege checker
`include "ppc_defs.svh"
`default_nettype none
module ppc_checker_tb import ppc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clock_i, reset_n_i = 1'b0, ce_i = 1'b1, req_valid_i = 1'b0, desc_present_i = 1'b1, priv_fail_i = 1'b0;
  logic call_gate_i = 1'b0, access_write_i = 1'b0, exc_is_fault_i = 1'b0;
  ppc_op_t req_op_i = PPC_OP_SEG_LOAD;
  ppc_seg_t req_seg_i = SEG_DS;
  ppc_dclass_t desc_class_i = DC_DATA_RW;
  ppc_pinstr_t pinstr_i = PI_NONE;
  logic [15:0] req_selector_i = '0, table_limit_i = 16'hffff, desc_limit_i = '0, cur_ss_i = '0, cur_sp_i = '0;
  logic [15:0] popped_ss_i = '0, popped_sp_i = '0, ret_adjust_i = '0, op_base_i = '0, op_disp_i = '0;
  logic [15:0] seg_limit_i = 16'hffff, new_flags_i = '0, exc_err_sel_i = '0, instr_start_ip_i = '0, next_ip_i = '0;
  logic [23:0] desc_base_i = '0, task_base_o;
  logic [3:0] desc_type_i = 4'h1, busy_type_o;
  logic [1:0] target_level_i = '0, current_privilege_level_o;
  logic [4:0] gate_words_i = '0, copy_words_o;
  logic [2:0][15:0] tsb_stack_sel_i = '0, tsb_stack_ptr_i = '0;
  logic [7:0] exc_vector_i = '0, fault_vec_o;
  logic done_o, fault_o, err_push_o, restartable_o, stack_load_o, push_old_stack_o, task_switch_o, mark_busy_o;
  logic [15:0] err_code_o, ret_ip_o, stack_sel_o, stack_ptr_o, old_ss_o, old_sp_o, task_selector_register_o;
  logic [15:0] task_limit_o, flags_o;
  logic [31:0] seed = 32'd54;
  logic [31:0] r;
  int num_errors = 0, tests_run = 0;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
  ppc_checker ppc_checker_i (.*);
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] np_vec(input ppc_seg_t s);
    return (s == SEG_SS) ? `PPC_VEC_SS : `PPC_VEC_NP;
  endfunction
  // valid stays high between calls so it is never driven twice in one step
  task automatic go(input ppc_op_t op);
    req_op_i = op;
    req_valid_i = 1'b1;
    @(negedge clock_i);
    `CHK(done_o, 1'b1)
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (2) @(negedge clock_i);
    reset_n_i = 1'b1;
    `CHK(busy_type_o, `PPC_TYPE_TSB_AVAIL)
    for (int i = 0; i < 14; i++) begin
      pinstr_i = ppc_pinstr_t'(i);
      go(PPC_OP_PRIV);
      `CHK(fault_o, 1'b0)
    end
    desc_present_i = 1'b0;
    repeat (8) begin
      r = rnd();
      req_selector_i = r[15:0];
      req_seg_i = ppc_seg_t'(r[17:16]);
      instr_start_ip_i = r[31:16];
      go(PPC_OP_SEG_LOAD);
      `CHK(fault_vec_o, np_vec(req_seg_i))
      `CHK({fault_o, err_push_o, restartable_o}, 3'h7)
      `CHK(err_code_o, r[15:0] & `PPC_RPL_MASK)
      `CHK(ret_ip_o, r[31:16])
    end
    desc_present_i = 1'b1;
    table_limit_i = 16'h00ff;
    req_selector_i = 16'h0100;
    go(PPC_OP_SEG_LOAD);
    `CHK(fault_vec_o, `PPC_VEC_GP)
    table_limit_i = 16'hffff;
    req_seg_i = SEG_SS;
    desc_class_i = DC_DATA_RO;
    go(PPC_OP_SEG_LOAD);
    `CHK({fault_o, fault_vec_o}, {1'b1, `PPC_VEC_GP})
    desc_class_i = DC_DATA_RW;
    go(PPC_OP_SEG_LOAD);
    `CHK(fault_o, 1'b0)
    access_write_i = 1'b1;
    op_base_i = 16'hffff;
    op_disp_i = 16'h0002;
    seg_limit_i = 16'h0001;
    go(PPC_OP_OPERAND);
    `CHK(fault_o, 1'b0)
    op_disp_i = 16'h0003;
    go(PPC_OP_OPERAND);
    `CHK({fault_o, fault_vec_o}, {1'b1, `PPC_VEC_SS})
    req_seg_i = SEG_DS;
    desc_class_i = DC_CODE_RX;
    go(PPC_OP_OPERAND);
    `CHK(fault_vec_o, `PPC_VEC_GP)
    // exception delivery through an ordinary gate at the same level
    desc_class_i = DC_CALL_GATE;
    exc_is_fault_i = 1'b1;
    next_ip_i = 16'h0050;
    instr_start_ip_i = 16'h0040;
    for (int v = 8; v < 14; v++) begin
      exc_vector_i = 8'(v);
      go(PPC_OP_INT);
      `CHK(fault_vec_o, 8'(v))
      `CHK({err_push_o, restartable_o}, {v != 9, v inside {10, 11, 12}})
      `CHK(ret_ip_o, (v == 9) ? 16'h0050 : 16'h0040)
    end
    desc_class_i = DC_TASK_BLOCK;
    desc_limit_i = `PPC_TSB_MIN_LIMIT;
    go(PPC_OP_JMP);
    `CHK(fault_vec_o, `PPC_VEC_TSB)
    desc_limit_i = 16'h002c;
    desc_type_i = `PPC_TYPE_TSB_BUSY;
    go(PPC_OP_JMP);
    `CHK(fault_vec_o, `PPC_VEC_GP)
    desc_type_i = `PPC_TYPE_TSB_AVAIL;
    req_selector_i = 16'h0028;
    desc_base_i = 24'h012345;
    target_level_i = 2'h3;
    go(PPC_OP_JMP);
    `CHK({task_switch_o, mark_busy_o, busy_type_o}, 6'h33)
    `CHK({task_selector_register_o, task_base_o, task_limit_o}, {16'h0028, 24'h012345, 16'h002c})
    `CHK(current_privilege_level_o, 2'h3)
    for (int i = 0; i < 14; i++) begin
      pinstr_i = ppc_pinstr_t'(i);
      go(PPC_OP_PRIV);
      `CHK({fault_o, fault_vec_o}, {1'b1, `PPC_VEC_GP})
    end
    new_flags_i = 16'hffff;
    go(PPC_OP_FLAG_POP);
    `CHK({fault_o, flags_o}, {1'b0, 16'h9dff})
    // inward gate call from level 3 to level 0
    desc_class_i = DC_CALL_GATE;
    call_gate_i = 1'b1;
    target_level_i = 2'h0;
    gate_words_i = 5'h07;
    tsb_stack_sel_i[0] = 16'h0010;
    tsb_stack_ptr_i[0] = 16'h0200;
    cur_ss_i = 16'h0033;
    cur_sp_i = 16'h0100;
    go(PPC_OP_CALL);
    `CHK({stack_load_o, push_old_stack_o, stack_sel_o, stack_ptr_o}, {2'b11, 16'h0010, 16'h0200})
    `CHK({old_ss_o, old_sp_o, copy_words_o}, {16'h0033, 16'h0100, 5'h07})
    // frozen cycle: pulses and state hold while the enable is low
    ce_i = 1'b0;
    req_seg_i = SEG_DS;
    desc_present_i = 1'b0;
    req_op_i = PPC_OP_SEG_LOAD;
    @(negedge clock_i);
    `CHK({fault_o, push_old_stack_o, current_privilege_level_o}, 4'h4)
    ce_i = 1'b1;
    go(PPC_OP_SEG_LOAD);
    `CHK({fault_o, fault_vec_o}, {1'b1, `PPC_VEC_NP})
    desc_present_i = 1'b1;
    // outward return to level 2 with a stack adjustment; a plain return pops no flags
    req_selector_i = 16'h0042;
    popped_ss_i = 16'h0023;
    popped_sp_i = 16'h0300;
    ret_adjust_i = 16'h0004;
    go(PPC_OP_RET);
    `CHK({stack_load_o, push_old_stack_o, stack_sel_o, stack_ptr_o}, {2'h2, 16'h0023, 16'h0304})
    `CHK({current_privilege_level_o, flags_o}, {2'h2, 16'h9dff})
    // nested entry, return to the previous task, then an interrupt through a task gate
    desc_class_i = DC_TASK_BLOCK;
    req_selector_i = 16'h0030;
    target_level_i = 2'h1;
    new_flags_i = 16'h4000;
    go(PPC_OP_JMP);
    `CHK({task_switch_o, flags_o, current_privilege_level_o}, {1'b1, 16'h4000, 2'h1})
    req_selector_i = 16'h0028;
    desc_type_i = `PPC_TYPE_TSB_BUSY;
    go(PPC_OP_INT_RETURN);
    `CHK({task_switch_o, mark_busy_o, stack_load_o, task_selector_register_o}, {3'h4, 16'h0028})
    desc_class_i = DC_TASK_GATE;
    desc_type_i = `PPC_TYPE_TSB_AVAIL;
    req_selector_i = 16'h0030;
    go(PPC_OP_INT);
    `CHK({task_switch_o, mark_busy_o, task_selector_register_o}, {2'h3, 16'h0030})
    go(PPC_OP_LOAD_TASK_SEL);
    `CHK({fault_o, fault_vec_o, mark_busy_o}, {1'b1, `PPC_VEC_GP, 1'b0})
    desc_class_i = DC_DATA_RW;
    priv_fail_i = 1'b1;
    go(PPC_OP_SEG_LOAD);
    `CHK({fault_o, fault_vec_o, err_code_o}, {1'b1, `PPC_VEC_GP, 16'h0030})
    priv_fail_i = 1'b0;
    // second reset in mid-run while requests are still offered
    reset_n_i = 1'b0;
    @(negedge clock_i);
    reset_n_i = 1'b1;
    `CHK({done_o, flags_o, current_privilege_level_o, busy_type_o}, {1'b0, 16'h0000, 2'h0, `PPC_TYPE_TSB_AVAIL})
    `CHK(task_selector_register_o, 16'h0000)
    give_verdict();
  end
endmodule
`default_nettype wire
